// ===== src/spibsc_consts.svh
// register offsets, field positions and reset values of the spi configuration block
`ifndef SPIBSC_CONSTS_SVH
`define SPIBSC_CONSTS_SVH

`define SPIBSC_OFS_CONTROL_TWO       3'h1
`define SPIBSC_OFS_BAUD_RATE         3'h2
`define SPIBSC_OFS_STATUS            3'h3
`define SPIBSC_OFS_DATA              3'h5

`define SPIBSC_CTL2_MODE_FAULT_ENABLE 4
`define SPIBSC_CTL2_BIDIR_OUTPUT_EN   3
`define SPIBSC_CTL2_STOP_IN_WAIT      1
`define SPIBSC_CTL2_SINGLE_WIRE       0
`define SPIBSC_CTL2_IMPL_MASK         8'h1b
`define SPIBSC_CTL2_RESET             8'h00

`define SPIBSC_BAUD_PRESCALE_MSB      6
`define SPIBSC_BAUD_PRESCALE_LSB      4
`define SPIBSC_BAUD_DIVIDE_MSB        2
`define SPIBSC_BAUD_DIVIDE_LSB        0
`define SPIBSC_BAUD_IMPL_MASK         8'h77
`define SPIBSC_BAUD_RESET             8'h00

`define SPIBSC_STAT_RECEIVE_FULL      7
`define SPIBSC_STAT_TRANSMIT_EMPTY    5
`define SPIBSC_STAT_MODE_FAULT        4
`define SPIBSC_STAT_RESET             8'h20

`endif

// ===== src/spibsc_pkg.sv
// types shared by the spi configuration block
package spibsc_pkg;
   typedef logic [7:0] spibsc_byte_t;
   typedef logic [2:0] spibsc_addr_t;
   typedef logic [2:0] spibsc_field_t;
   typedef enum {SPIBSC_SS_SLAVE_IN, SPIBSC_SS_GPIO, SPIBSC_SS_FAULT_IN, SPIBSC_SS_AUTO_OUT} spibsc_ss_use_t;
endpackage

// ===== src/spibsc_rate_if.sv
// carrier between the register logic and the baud generator
`timescale 1ns/100ps
interface spibsc_rate_if;
   import spibsc_pkg::*;
   spibsc_field_t prescaleSel;
   spibsc_field_t divideSel;
   logic          run;
   logic          bitClock;
   logic          bitTick;
   modport cfg (output prescaleSel, output divideSel, output run, input bitClock, input bitTick);
   modport gen (input prescaleSel, input divideSel, input run, output bitClock, output bitTick);
endinterface

// ===== src/spibsc_baud_gen.sv
// prescaler and power-of-two divider making the master bit-rate clock
`timescale 1ns/100ps
`include "spibsc_consts.svh"
module spibsc_baud_gen (
   input wire logic clock,
   input wire logic sys_rst,
   spibsc_rate_if.gen rate
);
   import spibsc_pkg::*;

   logic [2:0] preCount;
   logic [6:0] divCount;
   logic       bitClock;
   logic       bitTick;

   // compare with >= so a field rewritten mid-count never strands the counter
   wire       preWrap  = (preCount >= rate.prescaleSel);
   wire [7:0] halfSpan = 8'h01 << rate.divideSel;
   wire [6:0] halfLimit = halfSpan[6:0] - 7'h01;
   wire       divWrap  = preWrap && (divCount >= halfLimit);

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         preCount <= 3'h0;
         divCount <= 7'h00;
         bitClock <= 1'b0;
         bitTick  <= 1'b0;
      end else if (!rate.run) begin
         preCount <= 3'h0;
         divCount <= 7'h00;
         bitClock <= 1'b0;
         bitTick  <= 1'b0;
      end else begin
         preCount <= preWrap ? 3'h0 : preCount + 3'h1;
         if (preWrap) begin
            divCount <= divWrap ? 7'h00 : divCount + 7'h01;
         end
         if (divWrap) begin
            bitClock <= ~bitClock;
         end
         bitTick <= divWrap;
      end
   end

   assign rate.bitClock = bitClock;
   assign rate.bitTick  = bitTick;

   a_prescale_wrap: assert property (@(posedge clock) disable iff (sys_rst)
      rate.run && preWrap && $stable(rate.run) |=> (preCount == 3'h0 || !rate.run))
      else $error("prescale counter did not restart at its limit");

   a_divide_toggle: assert property (@(posedge clock) disable iff (sys_rst)
      rate.run && divWrap |=> (bitClock != $past(bitClock)) || !rate.run)
      else $error("bit clock did not toggle at divider wrap");

   a_clock_stopped: assert property (@(posedge clock) disable iff (sys_rst)
      !rate.run |=> !bitClock && !bitTick)
      else $error("bit clock runs while generator is stopped");
endmodule

// ===== src/spibsc_config.sv
// spi control two, baud rate and status registers with pin steering
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/100ps
`include "spibsc_consts.svh"
module spibsc_config (
   input  wire logic                clock,
   input  wire logic                sys_rst,
   input  wire spibsc_pkg::spibsc_addr_t regAddr,
   input  wire spibsc_pkg::spibsc_byte_t regWriteData,
   input  wire logic                regWrite,
   input  wire logic                regRead,
   output spibsc_pkg::spibsc_byte_t regReadData,
   input  wire logic                masterSelect,
   input  wire logic                selectOutputEnable,
   input  wire logic                controlOneWrite,
   input  wire logic                waitMode,
   input  wire logic                transferDone,
   input  wire logic                bufferToShifter,
   input  wire spibsc_pkg::spibsc_byte_t receiveData,
   input  wire logic                shiftOut,
   input  wire logic                selectAssert,
   output logic                     shiftIn,
   output logic                     slaveSelected,
   output spibsc_pkg::spibsc_byte_t transmitData,
   output logic                     transmitWrite,
   output logic                     spiClockRun,
   output logic                     bitRateClock,
   output logic                     bitRateTick,
   output logic                     selectPinOwned,
   input  wire logic                selectPinIn,
   output logic                     selectPinOut,
   output logic                     selectPinOe,
   input  wire logic                mosiIn,
   output logic                     mosiOut,
   output logic                     mosiOe,
   input  wire logic                misoIn,
   output logic                     misoOut,
   output logic                     misoOe
);
   import spibsc_pkg::*;

   spibsc_byte_t   controlTwo;
   spibsc_byte_t   baudRate;
   logic           receiveFull;
   logic           transmitEmpty;
   logic           modeFault;
   logic           receiveArmed;
   logic           transmitArmed;
   logic           faultArmed;
   logic [1:0]     selectSync;
   logic [1:0]     mosiSync;
   logic [1:0]     misoSync;
   logic           selectPrev;
   spibsc_ss_use_t selectUse;

   spibsc_rate_if rate ();

   // ---- register decode
   wire hitControl = (regAddr == `SPIBSC_OFS_CONTROL_TWO);
   wire hitBaud    = (regAddr == `SPIBSC_OFS_BAUD_RATE);
   wire hitStatus  = (regAddr == `SPIBSC_OFS_STATUS);
   wire hitData    = (regAddr == `SPIBSC_OFS_DATA);

   wire writeControl = regWrite && hitControl;
   wire writeBaud    = regWrite && hitBaud;
   wire readStatus   = regRead && hitStatus;
   wire readData     = regRead && hitData;
   wire writeData    = regWrite && hitData;

   wire modeFaultEnable = controlTwo[`SPIBSC_CTL2_MODE_FAULT_ENABLE];
   wire bidirOutputEn   = controlTwo[`SPIBSC_CTL2_BIDIR_OUTPUT_EN];
   wire stopInWait      = controlTwo[`SPIBSC_CTL2_STOP_IN_WAIT];
   wire singleWire      = controlTwo[`SPIBSC_CTL2_SINGLE_WIRE];

   wire spibsc_byte_t statusValue = {receiveFull, 1'b0, transmitEmpty, modeFault, 4'h0};
   wire spibsc_byte_t controlValue = controlTwo & `SPIBSC_CTL2_IMPL_MASK;
   wire spibsc_byte_t baudValue    = baudRate & `SPIBSC_BAUD_IMPL_MASK;

   wire spibsc_byte_t readMux = hitControl ? controlValue :
                                hitBaud    ? baudValue :
                                hitStatus  ? statusValue :
                                hitData    ? receiveData : 8'h00;

   // ---- registers written by software
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         controlTwo <= `SPIBSC_CTL2_RESET;
      end else if (writeControl) begin
         controlTwo <= regWriteData & `SPIBSC_CTL2_IMPL_MASK;
      end
   end

   // no busy interlock: a rate change mid-frame is compared against the running counts at once
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         baudRate <= `SPIBSC_BAUD_RESET;
      end else if (writeBaud) begin
         baudRate <= regWriteData & `SPIBSC_BAUD_IMPL_MASK;
      end
   end

   // status writes decode to nothing, so they fall through here
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         regReadData <= 8'h00;
      end else if (regRead) begin
         regReadData <= readMux;
      end else begin
         regReadData <= 8'h00;
      end
   end

   // ---- pin synchronisers
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         selectSync <= 2'b11;
         mosiSync   <= 2'b00;
         misoSync   <= 2'b00;
         selectPrev <= 1'b1;
      end else begin
         selectSync <= {selectSync[0], selectPinIn};
         mosiSync   <= {mosiSync[0], mosiIn};
         misoSync   <= {misoSync[0], misoIn};
         selectPrev <= selectSync[1];
      end
   end

   // ---- select pin function
   always_comb begin
      if (!masterSelect) begin
         selectUse = SPIBSC_SS_SLAVE_IN;
      end else if (!modeFaultEnable) begin
         selectUse = SPIBSC_SS_GPIO;
      end else if (!selectOutputEnable) begin
         selectUse = SPIBSC_SS_FAULT_IN;
      end else begin
         selectUse = SPIBSC_SS_AUTO_OUT;
      end
   end

   always_comb begin
      selectPinOe    = 1'b0;
      selectPinOut   = 1'b1;
      selectPinOwned = 1'b1;
      slaveSelected  = 1'b0;
      case (selectUse)
         SPIBSC_SS_SLAVE_IN: begin
            slaveSelected = ~selectSync[1];
         end
         SPIBSC_SS_GPIO: begin
            selectPinOwned = 1'b0;
         end
         SPIBSC_SS_FAULT_IN: begin
            selectPinOe = 1'b0;
         end
         SPIBSC_SS_AUTO_OUT: begin
            selectPinOe  = 1'b1;
            selectPinOut = ~selectAssert;
         end
         default: begin
            selectPinOwned = 1'b0;
         end
      endcase
   end

   // a fall seen only through the synchronised level; a held-low pin faults once
   wire faultEvent = (selectUse == SPIBSC_SS_FAULT_IN) && selectPrev && !selectSync[1];

   // ---- data pin steering
   wire separatePins = !singleWire;
   // bidir enable matters only on the single shared pin
   wire sharedDrive  = singleWire && bidirOutputEn;

   assign mosiOut = shiftOut;
   assign misoOut = shiftOut;
   assign mosiOe  = masterSelect && (separatePins || sharedDrive);
   assign misoOe  = !masterSelect && (separatePins ? slaveSelected : sharedDrive);
   assign shiftIn = singleWire ? (masterSelect ? mosiSync[1] : misoSync[1]) :
                                 (masterSelect ? misoSync[1] : mosiSync[1]);

   // ---- clocks in wait mode
   assign spiClockRun = !(stopInWait && waitMode);

   assign rate.prescaleSel = baudRate[`SPIBSC_BAUD_PRESCALE_MSB:`SPIBSC_BAUD_PRESCALE_LSB];
   assign rate.divideSel   = baudRate[`SPIBSC_BAUD_DIVIDE_MSB:`SPIBSC_BAUD_DIVIDE_LSB];
   assign rate.run         = masterSelect && spiClockRun;
   assign bitRateClock     = rate.bitClock;
   assign bitRateTick      = rate.bitTick;

   spibsc_baud_gen u_spibsc_baud_gen (
      .clock   (clock),
      .sys_rst (sys_rst),
      .rate    (rate)
   );

   // ---- status flags; a set in the same cycle as a clear always wins
   wire receiveClear  = receiveArmed && readData && !transferDone;
   wire transmitClear = transmitArmed && writeData && !bufferToShifter;
   wire faultClear    = faultArmed && controlOneWrite && !faultEvent;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         receiveFull  <= 1'b0;
         receiveArmed <= 1'b0;
      end else begin
         if (transferDone) begin
            receiveFull  <= 1'b1;
            receiveArmed <= 1'b0;
         end else if (receiveClear) begin
            receiveFull  <= 1'b0;
            receiveArmed <= 1'b0;
         end else if (readStatus && receiveFull) begin
            receiveArmed <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         transmitEmpty <= 1'b1;
         transmitArmed <= 1'b0;
      end else begin
         if (bufferToShifter) begin
            transmitEmpty <= 1'b1;
         end else if (transmitClear) begin
            transmitEmpty <= 1'b0;
            transmitArmed <= 1'b0;
         end else if (readStatus && transmitEmpty) begin
            transmitArmed <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         modeFault  <= 1'b0;
         faultArmed <= 1'b0;
      end else begin
         if (faultEvent) begin
            modeFault  <= 1'b1;
            faultArmed <= 1'b0;
         end else if (faultClear) begin
            modeFault  <= 1'b0;
            faultArmed <= 1'b0;
         end else if (readStatus && modeFault) begin
            faultArmed <= 1'b1;
         end
      end
   end

   // data writes without the status-read handshake are dropped
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         transmitData  <= 8'h00;
         transmitWrite <= 1'b0;
      end else begin
         transmitWrite <= writeData && transmitArmed;
         if (writeData && transmitArmed) begin
            transmitData <= regWriteData;
         end
      end
   end

   // ---- checks
   a_ctl_reserved_zero: assert property (@(posedge clock) disable iff (sys_rst)
      regRead && hitControl |=> (regReadData[7:5] == 3'h0) && !regReadData[2])
      else $error("control two unused bits read nonzero");

   a_slave_select_in: assert property (@(posedge clock) disable iff (sys_rst)
      !masterSelect |-> !selectPinOe && selectPinOwned && (slaveSelected == !selectSync[1]))
      else $error("slave select pin not used as input in slave mode");

   a_select_released: assert property (@(posedge clock) disable iff (sys_rst)
      masterSelect && !modeFaultEnable |-> !selectPinOwned && !selectPinOe)
      else $error("select pin held while fault function is off");

   a_auto_select_out: assert property (@(posedge clock) disable iff (sys_rst)
      masterSelect && modeFaultEnable && selectOutputEnable |-> selectPinOe && (selectPinOut == !selectAssert))
      else $error("automatic select output not driven");

   a_bidir_input: assert property (@(posedge clock) disable iff (sys_rst)
      singleWire && !bidirOutputEn |-> !mosiOe && !misoOe)
      else $error("shared data pin driven with output enable clear");

   a_separate_pins: assert property (@(posedge clock) disable iff (sys_rst)
      !singleWire && masterSelect |-> mosiOe && !misoOe && (shiftIn == misoSync[1]))
      else $error("master does not use separate data pins");

   a_wait_stop: assert property (@(posedge clock) disable iff (sys_rst)
      stopInWait && waitMode && masterSelect |=> !bitRateClock && !bitRateTick)
      else $error("bit clock still runs in wait with stop set");

   a_status_reserved: assert property (@(posedge clock) disable iff (sys_rst)
      regRead && hitStatus |=> (regReadData & 8'h4f) == 8'h00)
      else $error("status unused bits read nonzero");

   a_receive_clear: assert property (@(posedge clock) disable iff (sys_rst)
      receiveArmed && readData && !transferDone |=> !receiveFull ##1 (!receiveFull || $past(transferDone)))
      else $error("receive full not cleared by read sequence");

   a_transmit_hold: assert property (@(posedge clock) disable iff (sys_rst)
      writeData && !transmitArmed |=> !transmitWrite && $stable(transmitData))
      else $error("unarmed data write was accepted");

   a_fault_gate: assert property (@(posedge clock) disable iff (sys_rst)
      !modeFault && !(masterSelect && modeFaultEnable && !selectOutputEnable) |=> !modeFault)
      else $error("mode fault set outside master fault-input mode");
endmodule

// ===== verification/spibsc_far_end.sv
// far-side spi device driving whichever data lines the block leaves free
`timescale 1ns/100ps
module spibsc_far_end (
   input  wire logic clock,
   input  wire logic farSelectLow,
   input  wire logic farBit,
   input  wire logic mosiOut,
   input  wire logic mosiOe,
   input  wire logic misoOut,
   input  wire logic misoOe,
   input  wire logic selectPinOut,
   input  wire logic selectPinOe,
   output logic      mosiIn,
   output logic      misoIn,
   output logic      selectPinIn
);
   // a free data line carries the far bit; select has a pull-up when nobody pulls it
   assign mosiIn      = mosiOe ? mosiOut : farBit;
   assign misoIn      = misoOe ? misoOut : farBit;
   assign selectPinIn = selectPinOe ? selectPinOut : !farSelectLow;
endmodule

// ===== verification/spi_pin_baud_status_config_bench.sv
// self-checking bench for the spi configuration block
`timescale 1ns/100ps
`include "spibsc_consts.svh"
module spi_pin_baud_status_config_bench;
   import spibsc_pkg::*;
   logic clock, sys_rst, regWrite, regRead, masterSelect, selectOutputEnable, controlOneWrite, waitMode;
   logic transferDone, bufferToShifter, shiftOut, selectAssert, shiftIn, slaveSelected, transmitWrite;
   logic spiClockRun, bitRateClock, bitRateTick, selectPinOwned, selectPinIn, selectPinOut, selectPinOe;
   logic mosiIn, mosiOut, mosiOe, misoIn, misoOut, misoOe, farSelectLow, farBit;
   spibsc_addr_t regAddr;
   spibsc_byte_t regWriteData, regReadData, receiveData, transmitData, d;
   int miscompares, n_checks;

   spibsc_config u_spibsc_config (.clock(clock), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
      .masterSelect(masterSelect), .selectOutputEnable(selectOutputEnable), .controlOneWrite(controlOneWrite),
      .waitMode(waitMode), .transferDone(transferDone), .bufferToShifter(bufferToShifter),
      .receiveData(receiveData), .shiftOut(shiftOut), .selectAssert(selectAssert), .shiftIn(shiftIn),
      .slaveSelected(slaveSelected), .transmitData(transmitData), .transmitWrite(transmitWrite),
      .spiClockRun(spiClockRun), .bitRateClock(bitRateClock), .bitRateTick(bitRateTick),
      .selectPinOwned(selectPinOwned), .selectPinIn(selectPinIn), .selectPinOut(selectPinOut),
      .selectPinOe(selectPinOe), .mosiIn(mosiIn), .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoIn),
      .misoOut(misoOut), .misoOe(misoOe));
   spibsc_far_end u_spibsc_far_end (.clock(clock), .farSelectLow(farSelectLow), .farBit(farBit),
      .mosiOut(mosiOut), .mosiOe(mosiOe), .misoOut(misoOut), .misoOe(misoOe), .selectPinOut(selectPinOut),
      .selectPinOe(selectPinOe), .mosiIn(mosiIn), .misoIn(misoIn), .selectPinIn(selectPinIn));

   initial begin
      clock = 0;
      forever #50 clock = ~clock;
   end

   task automatic complete_run();
      if (miscompares == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk8(input spibsc_byte_t got, input spibsc_byte_t exp, input string what);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t %s: got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic wr(input spibsc_addr_t a, input spibsc_byte_t v);
      @(posedge clock);
      regWrite <= 1'b1;
      regAddr <= a;
      regWriteData <= v;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask

   // data stand only in the cycle after the strobe, so look at the falling edge
   task automatic rd(input spibsc_addr_t a, output spibsc_byte_t v);
      @(posedge clock);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRead <= 1'b0;
      @(negedge clock);
      v = regReadData;
   endtask

   task automatic rd_chk(input spibsc_addr_t a, input spibsc_byte_t exp, input string what);
      spibsc_byte_t v;
      rd(a, v);
      chk8(v, exp, what);
   endtask

   task automatic test_registers();
      rd_chk(`SPIBSC_OFS_CONTROL_TWO, 8'h00, "control two reset");
      rd_chk(`SPIBSC_OFS_STATUS, 8'h20, "status reset");
      wr(`SPIBSC_OFS_CONTROL_TWO, 8'hff);
      rd_chk(`SPIBSC_OFS_CONTROL_TWO, 8'h1b, "control two mask");
      wr(`SPIBSC_OFS_BAUD_RATE, 8'hff);
      rd_chk(`SPIBSC_OFS_BAUD_RATE, 8'h77, "baud mask");
      wr(`SPIBSC_OFS_STATUS, 8'hff);
      rd_chk(`SPIBSC_OFS_STATUS, 8'h20, "status write");
      wr(3'h7, 8'hff);
      rd_chk(3'h7, 8'h00, "unmapped read");
      wr(`SPIBSC_OFS_CONTROL_TWO, 8'h00);
   endtask

   task automatic test_select_pin();
      logic m, f, s;
      for (int i = 0; i < 8; i++) begin
         {m, f, s} = i[2:0];
         masterSelect <= m;
         selectOutputEnable <= s;
         wr(`SPIBSC_OFS_CONTROL_TWO, {3'h0, f, 4'h0});
         @(negedge clock);
         chk1(selectPinOwned, !m || f, "select pin owner");
         chk1(selectPinOe, m && f && s, "select pin drive");
         if (m && f && s) chk1(selectPinOut, 1'b0, "auto select level");
      end
      selectAssert <= 1'b0;
   endtask

   task automatic test_data_pins();
      logic m, w, b;
      for (int i = 0; i < 8; i++) begin
         {m, w, b} = i[2:0];
         masterSelect <= m;
         farSelectLow <= !m;
         // far bit opposite to own output, so a wrong pin choice shows up
         farBit <= i[0];
         shiftOut <= !i[0];
         wr(`SPIBSC_OFS_CONTROL_TWO, {4'h0, b, 2'h0, w});
         repeat (4) @(negedge clock);
         chk1(mosiOe, w ? m && b : m, "mosi drive");
         chk1(misoOe, w ? !m && b : !m, "miso drive");
         if (!m) chk1(slaveSelected, 1'b1, "slave selected");
         if (!(w && b)) chk1(shiftIn, farBit, "serial input pin");
         chk1(mosiOut, !i[0], "mosi data");
         chk1(misoOut, !i[0], "miso data");
      end
      farSelectLow <= 1'b0;
   endtask

   task automatic measure(input logic [2:0] p, input logic [2:0] r);
      int n;
      int seen;
      logic prev;
      wr(`SPIBSC_OFS_BAUD_RATE, {1'b0, p, 1'b0, r});
      seen = 0;
      n = 0;
      prev = 1'b1;
      for (int k = 0; k < 3000 && seen < 2; k++) begin
         @(negedge clock);
         if (seen == 1) n++;
         if (bitRateClock === 1'b1 && prev === 1'b0) seen++;
         if (k > 0) chk1(bitRateTick, bitRateClock !== prev, "bit tick at toggle");
         prev = bitRateClock;
      end
      chk8(spibsc_byte_t'(n >> 1), spibsc_byte_t'(((p + 1) << (r + 1)) >> 1), "bit clock half period");
   endtask

   task automatic test_baud();
      masterSelect <= 1'b1;
      wr(`SPIBSC_OFS_CONTROL_TWO, 8'h00);
      measure(3'h0, 3'h0);
      measure(3'h2, 3'h1);
      measure(3'h7, 3'h2);
      measure(3'h0, 3'h7);
      measure(3'h7, 3'h0);
      wr(`SPIBSC_OFS_BAUD_RATE, 8'h00);
      waitMode <= 1'b1;
      wr(`SPIBSC_OFS_CONTROL_TWO, 8'h02);
      repeat (3) @(negedge clock);
      chk1(spiClockRun, 1'b0, "clock stopped in wait");
      repeat (8) begin
         @(negedge clock);
         chk1(bitRateClock, 1'b0, "bit clock held");
      end
      wr(`SPIBSC_OFS_CONTROL_TWO, 8'h00);
      @(negedge clock);
      chk1(spiClockRun, 1'b1, "clock runs in wait");
      waitMode <= 1'b0;
   endtask

   task automatic test_flags();
      @(posedge clock) transferDone <= 1'b1;
      @(posedge clock) transferDone <= 1'b0;
      rd(`SPIBSC_OFS_DATA, d);
      rd_chk(`SPIBSC_OFS_STATUS, 8'ha0, "receive full held");
      rd_chk(`SPIBSC_OFS_DATA, 8'h5a, "receive data");
      rd_chk(`SPIBSC_OFS_STATUS, 8'h20, "receive full cleared");
      rd(`SPIBSC_OFS_STATUS, d);
      wr(`SPIBSC_OFS_DATA, 8'h3c);
      @(negedge clock);
      chk1(transmitWrite, 1'b1, "armed data write");
      chk8(transmitData, 8'h3c, "transmit byte");
      rd_chk(`SPIBSC_OFS_STATUS, 8'h00, "transmit empty cleared");
      wr(`SPIBSC_OFS_DATA, 8'hc3);
      @(negedge clock);
      chk1(transmitWrite, 1'b0, "unarmed write dropped");
      @(posedge clock) bufferToShifter <= 1'b1;
      @(posedge clock) bufferToShifter <= 1'b0;
      rd_chk(`SPIBSC_OFS_STATUS, 8'h20, "transmit empty set");
      masterSelect <= 1'b1;
      selectOutputEnable <= 1'b1;
      wr(`SPIBSC_OFS_CONTROL_TWO, 8'h10);
      farSelectLow <= 1'b1;
      repeat (6) @(posedge clock);
      rd_chk(`SPIBSC_OFS_STATUS, 8'h20, "no fault with select output");
      chk1(selectPinOut, 1'b1, "auto select idle level");
      farSelectLow <= 1'b0;
      selectOutputEnable <= 1'b0;
      repeat (6) @(posedge clock);
      farSelectLow <= 1'b1;
      repeat (6) @(posedge clock);
      rd_chk(`SPIBSC_OFS_STATUS, 8'h30, "mode fault set");
      @(posedge clock) controlOneWrite <= 1'b1;
      @(posedge clock) controlOneWrite <= 1'b0;
      rd_chk(`SPIBSC_OFS_STATUS, 8'h20, "mode fault cleared");
   endtask

   initial begin
      miscompares = 0;
      n_checks = 0;
      sys_rst = 1'b1;
      {regWrite, regRead, masterSelect, selectOutputEnable, controlOneWrite, waitMode} = '0;
      {transferDone, bufferToShifter, shiftOut, farSelectLow, farBit} = '0;
      selectAssert = 1'b1;
      regAddr = '0;
      regWriteData = '0;
      receiveData = 8'h5a;
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      test_registers();
      test_select_pin();
      test_data_pins();
      test_baud();
      test_flags();
      complete_run();
   end

   // tests need well under 10k cycles
   initial begin
      #(100 * 20000);
      miscompares++;
      complete_run();
   end
endmodule
